/* hw/sdram_cmd_map.vh */
// command codes, bank states and geometry constants for the sdram command decoder
`ifndef SDRAM_CMD_MAP_VH
`define SDRAM_CMD_MAP_VH
// {row strobe, column strobe, write enable} with chip select low
`define CMD_ROW_OPEN      3'h3
`define CMD_PRECHARGE     3'h2
`define CMD_READ          3'h5
`define CMD_WRITE         3'h4
// bank states
`define BANK_IDLE         2'h0
`define BANK_ACTIVE       2'h1
`define BANK_PRECHARGING  2'h2
// address bit that selects precharge of all banks
`define ADDR_ALL_BIT      10
// precharge duration in cycles
`define PRECHARGE_CYCLES  4'h3
// reset values, then row and column address widths
`define CNT_RESET         4'h0
`define DATA_RESET        32'h00000000
`define OE_RESET          4'h0
`define ROW_BITS          11
`define COL_BITS          8
`endif

/* hw/sdram_command_strobe_decode.v */
// sdram command strobe decoder with bank state tracking, byte-masked storage and read data path
`timescale 1ns/100ps
`include "sdram_cmd_map.vh"
module sdram_command_strobe_decode #(
  parameter DEPTH_BITS = 6
) (
  // clock and reset
  input  wire        clock_i,
  input  wire        rst_i,
  // command
  input  wire        chip_select_n_i,
  input  wire        row_strobe_n_i,
  input  wire        col_strobe_n_i,
  input  wire        write_enable_n_i,
  input  wire [1:0]  bank_addr_i,
  input  wire [10:0] addr_i,
  // data
  input  wire [3:0]  byte_mask_i,
  input  wire [31:0] data_i,
  output reg  [31:0] data_o,
  output reg  [3:0]  data_oe_o,
  // status
  output wire [7:0]  bank_state_o
);


  // bank state codes
  localparam [1:0] ST_IDLE        = `BANK_IDLE;
  localparam [1:0] ST_ACTIVE      = `BANK_ACTIVE;
  localparam [1:0] ST_PRECHARGING = `BANK_PRECHARGING;

  // command codes on {row strobe, column strobe, write enable}
  localparam [2:0] OP_ROW_OPEN    = `CMD_ROW_OPEN;
  localparam [2:0] OP_PRECHARGE   = `CMD_PRECHARGE;
  localparam [2:0] OP_READ        = `CMD_READ;
  localparam [2:0] OP_WRITE       = `CMD_WRITE;

  // geometry of the reduced storage model
  localparam       BANKS          = 4;
  localparam       LANES          = 4;
  localparam       ADDR_W         = 2 * DEPTH_BITS + 2;
  localparam       WORDS          = 1 << ADDR_W;

  // precharge countdown
  localparam [3:0] PRE_LOAD       = `PRECHARGE_CYCLES;
  localparam [3:0] PRE_LAST       = 4'h1;
  localparam [3:0] PRE_STEP       = 4'h1;
  localparam [3:0] PRE_CLEAR      = `CNT_RESET;

  // command decode
  wire [2:0]                  cmd;
  wire                        sel;
  wire                        is_open;
  wire                        is_pre;
  wire                        is_wr;
  wire                        is_rd;

  // addressed bank
  wire [2*BANKS-1:0]          state_bus;
  wire [DEPTH_BITS*BANKS-1:0] row_bus;
  wire [1:0]                  sel_state;
  wire [DEPTH_BITS-1:0]       sel_row;
  wire                        bank_active;
  wire                        wr_ok;
  wire                        rd_ok;
  wire [ADDR_W-1:0]           waddr;

  // read path
  wire [8*LANES-1:0]          rd_word;
  wire [LANES-1:0]            oe_next;

  assign cmd     = {row_strobe_n_i, col_strobe_n_i, write_enable_n_i};

  assign sel     = ~chip_select_n_i;

  assign is_open = sel && (cmd == OP_ROW_OPEN);

  assign is_pre  = sel && (cmd == OP_PRECHARGE);

  // column access, write when enable low
  assign is_wr   = sel && (cmd == OP_WRITE);
  assign is_rd   = sel && (cmd == OP_READ);

  assign sel_state   = state_bus[2*bank_addr_i +: 2];
  assign sel_row     = row_bus[DEPTH_BITS*bank_addr_i +: DEPTH_BITS];
  assign bank_active = (sel_state == ST_ACTIVE);

  // access to a bank that is not open is dropped: no store, no drive
  assign wr_ok   = is_wr && bank_active;
  assign rd_ok   = is_rd && bank_active;

  // only DEPTH_BITS of row and column are kept, so rows alias beyond that window
  assign waddr   = {bank_addr_i, sel_row, addr_i[DEPTH_BITS-1:0]};

  assign bank_state_o = state_bus;

  genvar b;
  generate
    for (b = 0; b < BANKS; b = b + 1) begin : g_bank
      reg  [1:0]            state_reg;
      reg  [1:0]            state_next;
      reg  [3:0]            cnt_reg;
      reg  [3:0]            cnt_next;
      reg  [DEPTH_BITS-1:0] row_reg;
      reg  [DEPTH_BITS-1:0] row_next;
      wire                  hit;
      wire                  pre_hit;

      assign hit     = ({30'h0, bank_addr_i} == b);

      assign pre_hit = is_pre && (addr_i[`ADDR_ALL_BIT] || hit);

      always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        row_next   = row_reg;
        if (is_open && hit) begin
          state_next = ST_ACTIVE;
          row_next   = addr_i[DEPTH_BITS-1:0];
        end else if (pre_hit) begin
          state_next = ST_PRECHARGING;
          cnt_next   = PRE_LOAD;
        end else begin
          case (state_reg)
            ST_PRECHARGING: begin
              cnt_next = cnt_reg - PRE_STEP;
              if (cnt_reg == PRE_LAST) begin
                state_next = ST_IDLE;
              end
            end
            ST_IDLE: begin
              cnt_next = PRE_CLEAR;
            end
            ST_ACTIVE: begin
              cnt_next = PRE_CLEAR;
            end
            default: begin
              // an unused code falls back to idle rather than locking the bank
              state_next = ST_IDLE;
              cnt_next   = PRE_CLEAR;
            end
          endcase
        end
      end

      always @(posedge clock_i) begin
        if (rst_i) begin
          state_reg <= ST_IDLE;
          cnt_reg   <= PRE_CLEAR;
          row_reg   <= {DEPTH_BITS{1'b0}};
        end else begin
          state_reg <= state_next;
          cnt_reg   <= cnt_next;
          row_reg   <= row_next;
        end
      end

      assign state_bus[2*b+1:2*b]                            = state_reg;
      assign row_bus[DEPTH_BITS*b+DEPTH_BITS-1:DEPTH_BITS*b] = row_reg;
    end
  endgenerate

  genvar l;
  generate
    for (l = 0; l < LANES; l = l + 1) begin : g_lane
      reg  [7:0] lane_mem [0:WORDS-1];
      wire       store;

      assign store = wr_ok && !byte_mask_i[l];

      always @(posedge clock_i) begin
        if (store) begin
          lane_mem[waddr] <= data_i[8*l+7:8*l];
        end
      end

      assign rd_word[8*l+7:8*l] = lane_mem[waddr];
      assign oe_next[l]         = rd_ok && !byte_mask_i[l];
    end
  endgenerate

  always @(posedge clock_i) begin
    if (rst_i) begin
      data_o    <= `DATA_RESET;
      data_oe_o <= `OE_RESET;
    end else begin
      data_o    <= rd_word;
      data_oe_o <= oe_next;
    end
  end

endmodule

/* testbench/ctl_model.sv */
// controller model driving one command per cycle
`timescale 1ns/100ps
module ctl_model(input wire clock_i, input wire [52:0] req_i, output reg [52:0] pin_o = {1'b1, 52'h0});
  // pins move together off the edge; a released data bus toggles
  always @(negedge clock_i) pin_o <= (req_i[52] | req_i[49]) ? {req_i[52:32], ~pin_o[31:0]} : req_i;
endmodule

/* testbench/sdram_cmd_chk.sv */
// assertions for the sdram command decoder
`timescale 1ns/100ps
module sdram_cmd_chk(input wire clock_i, rst_i, chip_select_n_i, row_strobe_n_i, col_strobe_n_i, write_enable_n_i,
  input wire [1:0] bank_addr_i, input wire [10:0] addr_i, input wire [3:0] byte_mask_i, data_oe_o,
  input wire [7:0] bank_state_o);
  wire [3:0] k = {chip_select_n_i, row_strobe_n_i, col_strobe_n_i, write_enable_n_i};
  wire [1:0] st = bank_state_o[2*bank_addr_i+:2];
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence pre0; k == 4'h2 && !addr_i[10] && bank_addr_i == 2'h0 && st == 2'h1; endsequence
  a_open_bank: assert property (k == 4'h3 |=> bank_state_o[2*$past(bank_addr_i)+:2] == 2'h1) else $error("open");
  a_pre_start: assert property (pre0 |=> bank_state_o[1:0] == 2'h2) else $error("pre");
  a_pre_end: assert property (pre0 ##1 chip_select_n_i [*3] |=> bank_state_o[1:0] == 2'h0) else $error("idle");
  a_pre_all: assert property (k == 4'h2 && addr_i[10] |=> (bank_state_o & 8'h55) == 8'h00) else $error("all");
  a_read_lanes: assert property (k == 4'h5 && st == 2'h1 |=> data_oe_o == ~$past(byte_mask_i)) else $error("oe");
  a_read_refused: assert property (k == 4'h5 && st != 2'h1 |=> data_oe_o == 4'h0) else $error("refused");
  a_write_quiet: assert property (k == 4'h4 |=> data_oe_o == 4'h0) else $error("write");
  a_deselect_hold: assert property (k[3] && (bank_state_o & 8'hAA) == 8'h00 |=> data_oe_o == 4'h0 &&
    $stable(bank_state_o)) else $error("deselect");
endmodule
bind sdram_command_strobe_decode sdram_cmd_chk chk (.*);

/* testbench/sdram_command_strobe_decode_tb_top.sv */
// bench for the sdram command decoder
`timescale 1ns/100ps
module sdram_command_strobe_decode_tb_top;
  reg clock_i = 0, rst_i = 1;
  reg [52:0] req = {1'b1, 52'h0};
  wire chip_select_n_i, row_strobe_n_i, col_strobe_n_i, write_enable_n_i;
  wire [1:0] bank_addr_i;
  wire [10:0] addr_i;
  wire [3:0] byte_mask_i, data_oe_o;
  wire [31:0] data_i, data_o;
  wire [7:0] bank_state_o;
  reg [15:0] r = 16'hBFF9;
  reg [31:0] d;
  reg [3:0] m, n;
  reg [35:0] q[$];
  int failures = 0, compares = 0, cyc = 0;
  always #2.5 clock_i = ~clock_i;
  ctl_model m0 (.clock_i, .req_i(req), .pin_o({chip_select_n_i, row_strobe_n_i, col_strobe_n_i, write_enable_n_i,
    bank_addr_i, addr_i, byte_mask_i, data_i}));
  sdram_command_strobe_decode dut (.*);
  function [15:0] nx(input [15:0] v); nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]}; endfunction
  function [31:0] ln(input [3:0] v); ln = {{8{v[3]}}, {8{v[2]}}, {8{v[1]}}, {8{v[0]}}}; endfunction
  task x(input [5:0] k, input [10:0] a, input [3:0] b, input [31:0] v);
    @(posedge clock_i) req <= {k, a, b, v};
    r = nx(r);
  endtask
  task complete_run;
    if (q.size() != 0) failures++;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // outputs are looked at mid-cycle, where they have settled
  always @(negedge clock_i) begin
    cyc++;
    if (cyc > 900) begin failures++; complete_run; end
    if (data_oe_o !== 4'h0) begin
      compares++;
      if ({data_oe_o, data_o & ln(data_oe_o)} !== q.pop_front()) begin
        failures++;
        $display("ERROR %0t read data", $time);
      end
    end
  end
  initial begin
    repeat (16) @(negedge clock_i);
    rst_i = 0;
    for (int b = 0; b < 4; b++) begin
      d = {r, nx(r)};
      m = r[3:0];
      n = r[7:4];
      x({4'h3, b[1:0]}, r[10:0], 0, 0);
      x({4'h4, b[1:0]}, 5, 0, ~d);
      x({4'hC, b[1:0]}, 5, 0, d);
      x({4'h4, b[1:0]}, 5, m, d);
      x({4'h5, b[1:0]}, 5, n, 0);
      if (n != 4'hF) q.push_back({~n, (d ^ ln(m)) & ln(~n)});
      x({4'h2, b[1:0]}, 0, 0, 0);
      repeat (4) x(6'h3C, 0, 0, 0);
      x({4'h5, b[1:0]}, 5, 0, 0);
      $display("bank %0d done", b);
    end
    for (int b = 0; b < 4; b++) x({4'h3, b[1:0]}, 0, 0, 0);
    x(6'h08, 11'h400, 0, 0);
    repeat (6) x(6'h3C, 0, 0, 0);
    $display("precharge all done");
    complete_run;
  end
endmodule
